// *** common/htg_params.svh ***
// Constants for the horizontal timing generator
`ifndef HTG_PARAMS_SVH
`define HTG_PARAMS_SVH

// Last fine edge position in one pixel period
`define HTG_POS_LAST 6'h2f
// Positions per quadrant of an edge code
`define HTG_QUAD_SPAN 6'h0c
// Half a pixel period, width of a sample pulse
`define HTG_SAMPLE_HALF 6'h18
// Pixel clock edges from line sync fall to counter reset
`define HTG_SYNC_DELAY 3'h6
// Drive current per code step, in tenths of a mA
`define HTG_CURRENT_STEP 8'h23
// Largest pixel count
`define HTG_PIX_MAX 12'hfff

`endif

// *** common/htg_pkg.sv ***
// Types shared by the horizontal timing generator files
package htg_pkg;

    // One clamp or blank sequence
    typedef struct packed {
        logic start_level;
        logic [11:0] first_toggle;
        logic [11:0] second_toggle;
    } htg_seq_t;

    // Sequences, region starts and pointers of one pulse signal
    typedef struct packed {
        htg_seq_t [3:0] seq;
        logic [2:0][11:0] region_start_line;
        logic [3:0][1:0] region_sequence_select;
    } htg_sig_cfg_t;

    // Programmable edges of one high-speed clock
    typedef struct packed {
        logic clock_invert_select;
        logic [5:0] rising_edge_place;
        logic [5:0] falling_edge_place;
        logic [2:0] output_current_step;
    } htg_edge_cfg_t;

    // Pad controls of one driven output
    typedef struct packed {
        logic oe;
        logic [7:0] current_tenths;
    } htg_pad_t;

    // Line sync alignment states
    typedef enum logic [1:0] {
        HTG_SYNC_IDLE = 2'b00,
        HTG_SYNC_COUNT = 2'b01
    } htg_sync_state_t;

endpackage

// *** core/htg_seq_gen.sv ***
// One clamp or blank pulse built from four sequences over four regions
`timescale 1ns/1ns
module htg_seq_gen
    import htg_pkg::*;
#(
    parameter logic HAS_START = 1'b1,
    parameter logic IDLE_LEVEL = 1'b1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pixel_tick,
    input wire logic line_restart,
    input wire logic [11:0] pixel_next,
    input wire logic [11:0] line_count,
    input wire htg_sig_cfg_t cfg,
    output logic pulse,
    output logic seq_flag
);

    logic level_reg;
    logic level_next;
    logic flag_reg;
    logic flag_next;
    logic [1:0] region;
    htg_seq_t cur_seq;

    //--------------------------------------------------
    // Region and sequence choice
    //--------------------------------------------------
    // Last region start passed picks the region
    always_comb begin
        region = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (line_count >= cfg.region_start_line[i]) begin
                region = 2'(i + 1);
            end
        end
        cur_seq = cfg.seq[cfg.region_sequence_select[region]];
    end

    //--------------------------------------------------
    // Pulse level
    //--------------------------------------------------
    // Start level at line start, then toggle on matching pixels
    always_comb begin
        level_next = level_reg;
        flag_next = flag_reg;
        if (pixel_tick) begin
            if (line_restart) begin
                level_next = HAS_START ? cur_seq.start_level : 1'b0;
            end
            level_next = level_next ^ (pixel_next == cur_seq.first_toggle)
                ^ (pixel_next == cur_seq.second_toggle);
            flag_next = cur_seq.start_level;
        end
    end

    // Registers of the pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_reg <= IDLE_LEVEL;
            flag_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            flag_reg <= flag_next;
        end
    end

    assign pulse = level_reg;
    assign seq_flag = flag_reg;

    // Single toggle match flips the level
    a_single_toggle: assert property (@(posedge clock) disable iff (sys_rst)
        pixel_tick && !line_restart
        && ((pixel_next == cur_seq.first_toggle) != (pixel_next == cur_seq.second_toggle))
        |=> level_reg != $past(level_reg))
        else $error("pulse did not toggle at its toggle pixel");

endmodule // htg_seq_gen

// *** core/htg_timing_gen.sv ***
// Horizontal timing generator: fine edge clocks, sync and clamp/blank pulses
// How it works
// - Each pixel period is split into 48 fine positions for edge placement.
// - Reset gate has programmable rise and fall positions and inversion.
// - Phase a and phase b clocks each have rise, fall and inversion settings.
// - The second and fourth clocks are always inverses of first and third.
// - Edge codes: top two bits pick quadrant, low four give offset.
// - Only offsets 0 to 11 per quadrant are valid edge codes.
// - Inversion bit zero leaves clock as is, one inverts it.
// - Each sample clock has one rising position code.
// - Drive code steps 3.5 mA; code 0 disables the output.
// - Output data launches on a chosen position 0 to 47.
// - Clamp sequences start at start level, toggle at two positions.
// - Toggle positions are 12-bit pixel counts compared to pixel counter.
// - Clamp and preblank pulses are active low.
// - Four sequences exist per clamp and preblank signal.
// - Blanking has no start level; first toggle starts, second ends.
// - Masked blanking forces phase clocks low and inverses high.
// - Four blank sequences, each with mask bit and two toggles.
// - Region 0 starts at line 0; three programmable later starts.
// - Per region, a 2-bit pointer picks the signal's sequence.
// - Each pulse signal has its own region starts and pointers.
// - Pixel counter resets on sixth pixel clock after line sync falls.
`timescale 1ns/1ns
`include "htg_params.svh"
module htg_timing_gen
    import htg_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire htg_edge_cfg_t rg_cfg,
    input wire htg_edge_cfg_t phase_a_cfg,
    input wire htg_edge_cfg_t phase_b_cfg,
    input wire logic [2:0] phase_a_inv_drive,
    input wire logic [2:0] phase_b_inv_drive,
    input wire logic [5:0] reference_sample_place,
    input wire logic [5:0] data_sample_place,
    input wire logic [5:0] output_data_launch_edge,
    input wire htg_sig_cfg_t black_clamp_cfg,
    input wire htg_sig_cfg_t dummy_clamp_cfg,
    input wire htg_sig_cfg_t preblank_cfg,
    input wire htg_sig_cfg_t blank_cfg,
    input wire logic [DATA_W-1:0] adc_data,
    output logic reset_gate_clock,
    output logic hclk_phase_a,
    output logic hclk_phase_a_inv,
    output logic hclk_phase_b,
    output logic hclk_phase_b_inv,
    output logic reference_sample_clock,
    output logic data_sample_clock,
    output htg_pad_t [4:0] pad_ctrl,
    output logic [DATA_W-1:0] data_out,
    output logic data_launch_strobe,
    output logic black_clamp_pulse,
    output logic dummy_clamp_pulse,
    output logic preblank_pulse,
    output logic horizontal_blank_pulse,
    output logic [11:0] pixel_count,
    output logic [11:0] line_count
);

    //--------------------------------------------------
    // Helper functions
    //--------------------------------------------------
    // Quadrant edge code to fine position
    function automatic logic [5:0] edge_pos(input logic [5:0] code);
        edge_pos = 6'({4'h0, code[5:4]} * `HTG_QUAD_SPAN) + {2'h0, code[3:0]};
    endfunction

    // Next clock level from rise and fall positions, rise wins a tie
    function automatic logic edge_next(input logic cur, input logic [5:0] pos,
        input logic [5:0] rise, input logic [5:0] fall);
        if (pos == rise) begin
            edge_next = 1'b1;
        end else if (pos == fall) begin
            edge_next = 1'b0;
        end else begin
            edge_next = cur;
        end
    endfunction

    // Fine position half a period after a given one
    function automatic logic [5:0] half_later(input logic [5:0] pos);
        logic [6:0] sum;
        sum = {1'b0, pos} + {1'b0, `HTG_SAMPLE_HALF};
        if (sum > {1'b0, `HTG_POS_LAST}) begin
            sum = sum - {1'b0, `HTG_POS_LAST} - 7'h01;
        end
        half_later = sum[5:0];
    endfunction

    // Pad control from a drive code
    function automatic htg_pad_t pad_of(input logic [2:0] code);
        pad_of.oe = (code != 3'h0);
        pad_of.current_tenths = 8'({5'h00, code} * `HTG_CURRENT_STEP);
    endfunction

    //--------------------------------------------------
    // Fine position counter
    //--------------------------------------------------
    logic [5:0] pos_reg;
    logic [5:0] pos_next;
    logic pixel_tick;

    // One pixel period is 48 clock cycles
    always_comb begin
        pixel_tick = (pos_reg == `HTG_POS_LAST);
        pos_next = pixel_tick ? 6'h00 : pos_reg + 6'h01;
    end

    // Position register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pos_reg <= 6'h00;
        end else begin
            pos_reg <= pos_next;
        end
    end

    a_pos_wrap: assert property (@(posedge clock) disable iff (sys_rst)
        pos_reg == `HTG_POS_LAST |=> pos_reg == 6'h00 ##47 pos_reg == `HTG_POS_LAST)
        else $error("fine position did not wrap after 48 steps");

    //--------------------------------------------------
    // Sync input synchronisers
    //--------------------------------------------------
    logic [2:0] hd_sync_reg;
    logic [2:0] hd_sync_next;
    logic [2:0] vd_sync_reg;
    logic [2:0] vd_sync_next;
    logic hd_level_reg;
    logic hd_level_next;
    logic vd_level_reg;
    logic vd_level_next;
    logic hd_fall;
    logic vd_fall;

    // Three stages; a change counts when the last two agree
    always_comb begin
        hd_sync_next = {hd_sync_reg[1:0], line_sync};
        vd_sync_next = {vd_sync_reg[1:0], frame_sync};
        hd_level_next = hd_level_reg;
        vd_level_next = vd_level_reg;
        if (hd_sync_reg[1] == hd_sync_reg[2]) begin
            hd_level_next = hd_sync_reg[2];
        end
        if (vd_sync_reg[1] == vd_sync_reg[2]) begin
            vd_level_next = vd_sync_reg[2];
        end
        hd_fall = hd_level_reg && !hd_level_next;
        vd_fall = vd_level_reg && !vd_level_next;
    end

    // Synchroniser registers, idle high
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hd_sync_reg <= 3'h7;
            vd_sync_reg <= 3'h7;
            hd_level_reg <= 1'b1;
            vd_level_reg <= 1'b1;
        end else begin
            hd_sync_reg <= hd_sync_next;
            vd_sync_reg <= vd_sync_next;
            hd_level_reg <= hd_level_next;
            vd_level_reg <= vd_level_next;
        end
    end

    //--------------------------------------------------
    // Pixel and line counters
    //--------------------------------------------------
    htg_sync_state_t state_reg;
    htg_sync_state_t state_next;
    logic [2:0] wait_reg;
    logic [2:0] wait_next;
    logic [11:0] pix_reg;
    logic [11:0] pix_next;
    logic [11:0] line_reg;
    logic [11:0] line_next;
    logic line_restart;

    // Counter reset six pixel clocks after line sync falls
    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        line_restart = 1'b0;
        pix_next = pix_reg;
        line_next = line_reg;
        case (state_reg)
            HTG_SYNC_IDLE: begin
                state_next = HTG_SYNC_IDLE;
            end
            HTG_SYNC_COUNT: begin
                if (pixel_tick) begin
                    wait_next = wait_reg - 3'h1;
                    if (wait_reg == 3'h1) begin
                        line_restart = 1'b1;
                        state_next = HTG_SYNC_IDLE;
                    end
                end
            end
            default: begin
                state_next = HTG_SYNC_IDLE;
            end
        endcase
        if (hd_fall) begin
            state_next = HTG_SYNC_COUNT;
            wait_next = `HTG_SYNC_DELAY;
        end
        if (pixel_tick) begin
            if (line_restart) begin
                pix_next = 12'h000;
            end else if (pix_reg != `HTG_PIX_MAX) begin
                pix_next = pix_reg + 12'h001;
            end
        end
        if (vd_fall) begin
            line_next = 12'h000;
        end else if (hd_fall) begin
            line_next = line_reg + 12'h001;
        end
    end

    // Counter registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= HTG_SYNC_IDLE;
            wait_reg <= 3'h0;
            pix_reg <= 12'h000;
            line_reg <= 12'h000;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            pix_reg <= pix_next;
            line_reg <= line_next;
        end
    end

    assign pixel_count = pix_reg;
    assign line_count = line_reg;

    sequence s_sync_armed;
        hd_fall ##1 (state_reg == HTG_SYNC_COUNT && wait_reg == `HTG_SYNC_DELAY);
    endsequence

    a_sync_arm: assert property (@(posedge clock) disable iff (sys_rst)
        hd_fall |-> s_sync_armed)
        else $error("line sync fall did not arm the six pixel wait");

    a_pix_reset: assert property (@(posedge clock) disable iff (sys_rst)
        state_reg == HTG_SYNC_COUNT && wait_reg == 3'h1 && pixel_tick && !hd_fall
        |=> pix_reg == 12'h000)
        else $error("pixel counter not reset on sixth pixel clock");

    a_line_clear: assert property (@(posedge clock) disable iff (sys_rst)
        vd_fall |=> line_reg == 12'h000)
        else $error("frame sync did not clear the line counter");

    //--------------------------------------------------
    // Clamp and blank pulses
    //--------------------------------------------------
    logic blank_mask;

    // Each signal has its own sequences, region starts and pointers
    htg_seq_gen #(.HAS_START(1'b1), .IDLE_LEVEL(1'b1)) u_black_clamp (
        .clock(clock),
        .sys_rst(sys_rst),
        .pixel_tick(pixel_tick),
        .line_restart(line_restart),
        .pixel_next(pix_next),
        .line_count(line_reg),
        .cfg(black_clamp_cfg),
        .pulse(black_clamp_pulse),
        .seq_flag()
    );

    htg_seq_gen #(.HAS_START(1'b1), .IDLE_LEVEL(1'b1)) u_dummy_clamp (
        .clock(clock),
        .sys_rst(sys_rst),
        .pixel_tick(pixel_tick),
        .line_restart(line_restart),
        .pixel_next(pix_next),
        .line_count(line_reg),
        .cfg(dummy_clamp_cfg),
        .pulse(dummy_clamp_pulse),
        .seq_flag()
    );

    htg_seq_gen #(.HAS_START(1'b1), .IDLE_LEVEL(1'b1)) u_preblank (
        .clock(clock),
        .sys_rst(sys_rst),
        .pixel_tick(pixel_tick),
        .line_restart(line_restart),
        .pixel_next(pix_next),
        .line_count(line_reg),
        .cfg(preblank_cfg),
        .pulse(preblank_pulse),
        .seq_flag()
    );

    // Blank uses the start level field as its mask bit
    htg_seq_gen #(.HAS_START(1'b0), .IDLE_LEVEL(1'b0)) u_blank (
        .clock(clock),
        .sys_rst(sys_rst),
        .pixel_tick(pixel_tick),
        .line_restart(line_restart),
        .pixel_next(pix_next),
        .line_count(line_reg),
        .cfg(blank_cfg),
        .pulse(horizontal_blank_pulse),
        .seq_flag(blank_mask)
    );

    //--------------------------------------------------
    // High-speed clocks
    //--------------------------------------------------
    logic rg_raw_reg;
    logic rg_raw_next;
    logic ha_raw_reg;
    logic ha_raw_next;
    logic hb_raw_reg;
    logic hb_raw_next;
    logic shp_reg;
    logic shp_next;
    logic shd_reg;
    logic shd_next;
    logic rg_out_reg;
    logic rg_out_next;
    logic ha_out_reg;
    logic ha_out_next;
    logic hb_out_reg;
    logic hb_out_next;
    logic blank_force;
    logic [5:0] shp_rise;
    logic [5:0] shd_rise;

    // Raw edges, then inversion and blank masking
    always_comb begin
        shp_rise = edge_pos(reference_sample_place);
        shd_rise = edge_pos(data_sample_place);
        rg_raw_next = edge_next(rg_raw_reg, pos_reg, edge_pos(rg_cfg.rising_edge_place),
            edge_pos(rg_cfg.falling_edge_place));
        ha_raw_next = edge_next(ha_raw_reg, pos_reg, edge_pos(phase_a_cfg.rising_edge_place),
            edge_pos(phase_a_cfg.falling_edge_place));
        hb_raw_next = edge_next(hb_raw_reg, pos_reg, edge_pos(phase_b_cfg.rising_edge_place),
            edge_pos(phase_b_cfg.falling_edge_place));
        shp_next = edge_next(shp_reg, pos_reg, shp_rise, half_later(shp_rise));
        shd_next = edge_next(shd_reg, pos_reg, shd_rise, half_later(shd_rise));
        blank_force = horizontal_blank_pulse && blank_mask;
        rg_out_next = rg_raw_next ^ rg_cfg.clock_invert_select;
        ha_out_next = blank_force ? 1'b0 : ha_raw_next ^ phase_a_cfg.clock_invert_select;
        hb_out_next = blank_force ? 1'b0 : hb_raw_next ^ phase_b_cfg.clock_invert_select;
    end

    // Clock registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rg_raw_reg <= 1'b0;
            ha_raw_reg <= 1'b0;
            hb_raw_reg <= 1'b0;
            shp_reg <= 1'b0;
            shd_reg <= 1'b0;
            rg_out_reg <= 1'b0;
            ha_out_reg <= 1'b0;
            hb_out_reg <= 1'b0;
        end else begin
            rg_raw_reg <= rg_raw_next;
            ha_raw_reg <= ha_raw_next;
            hb_raw_reg <= hb_raw_next;
            shp_reg <= shp_next;
            shd_reg <= shd_next;
            rg_out_reg <= rg_out_next;
            ha_out_reg <= ha_out_next;
            hb_out_reg <= hb_out_next;
        end
    end

    assign reset_gate_clock = rg_out_reg;
    assign hclk_phase_a = ha_out_reg;
    assign hclk_phase_a_inv = !ha_out_reg;
    assign hclk_phase_b = hb_out_reg;
    assign hclk_phase_b_inv = !hb_out_reg;
    assign reference_sample_clock = shp_reg;
    assign data_sample_clock = shd_reg;

    a_rg_edges: assert property (@(posedge clock) disable iff (sys_rst)
        pos_reg == edge_pos(rg_cfg.rising_edge_place) && $stable(rg_cfg)
        |=> reset_gate_clock == !rg_cfg.clock_invert_select)
        else $error("reset gate did not rise at its programmed position");

    a_inverse_pair: assert property (@(posedge clock) disable iff (sys_rst)
        hclk_phase_a_inv == !hclk_phase_a && hclk_phase_b_inv == !hclk_phase_b)
        else $error("inverse horizontal clock not complementary");

    a_blank_mask: assert property (@(posedge clock) disable iff (sys_rst)
        blank_force |=> !hclk_phase_a && !hclk_phase_b && hclk_phase_a_inv)
        else $error("masked blanking did not force horizontal clocks");

    a_sample_place: assert property (@(posedge clock) disable iff (sys_rst)
        pos_reg == shp_rise |=> reference_sample_clock ##23 reference_sample_clock)
        else $error("reference sample clock not high at its position");

    //--------------------------------------------------
    // Pads and output data
    //--------------------------------------------------
    htg_pad_t [4:0] pad_reg;
    htg_pad_t [4:0] pad_next;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic launch_reg;
    logic launch_next;

    // Drive codes to pads, data latched on the launch position
    always_comb begin
        pad_next[0] = pad_of(rg_cfg.output_current_step);
        pad_next[1] = pad_of(phase_a_cfg.output_current_step);
        pad_next[2] = pad_of(phase_a_inv_drive);
        pad_next[3] = pad_of(phase_b_cfg.output_current_step);
        pad_next[4] = pad_of(phase_b_inv_drive);
        launch_next = (pos_reg == output_data_launch_edge);
        dout_next = launch_next ? adc_data : dout_reg;
    end

    // Pad and data registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pad_reg <= '0;
            dout_reg <= '0;
            launch_reg <= 1'b0;
        end else begin
            pad_reg <= pad_next;
            dout_reg <= dout_next;
            launch_reg <= launch_next;
        end
    end

    assign pad_ctrl = pad_reg;
    assign data_out = dout_reg;
    assign data_launch_strobe = launch_reg;

    a_launch_edge: assert property (@(posedge clock) disable iff (sys_rst)
        pos_reg == output_data_launch_edge |=> data_launch_strobe && data_out == $past(adc_data))
        else $error("output data not launched at programmed position");

    a_drive_off: assert property (@(posedge clock) disable iff (sys_rst)
        rg_cfg.output_current_step == 3'h0 |=> !pad_ctrl[0].oe)
        else $error("reset gate pad enabled with drive code zero");

endmodule // htg_timing_gen

// *** dv/htg_ccd_model.sv ***
// Sensor stand-in that counts charge shifts made by the horizontal clocks
`timescale 1ns/1ns
module htg_ccd_model (
    input wire logic hclk_phase_a,
    input wire logic hclk_phase_a_inv,
    output logic [15:0] shift_count
);
    // One shift per phase a rise while the pair stays complementary
    initial begin
        shift_count = 16'h0000;
        forever begin
            @(posedge hclk_phase_a);
            #1;
            if (hclk_phase_a_inv === 1'b0) shift_count = shift_count + 16'h0001;
        end
    end
endmodule // htg_ccd_model

// *** dv/test_ccd_horizontal_timing_gen.sv ***
// Self-checking bench for the horizontal timing generator
`timescale 1ns/1ns
module test_ccd_horizontal_timing_gen;
    import htg_pkg::*;
    logic clock, sys_rst, ls, fs, rgc, ha, hai, hb, hbi, rs, ds, stb, bcp, dcp, pbp, hbp;
    htg_edge_cfg_t rg, pa, pb;
    htg_sig_cfg_t bc, dc, pk, hk;
    htg_pad_t [4:0] pad;
    logic [11:0] dout, pix, lin, ad;
    logic [15:0] sh, sh0;
    int error_cnt, check_count, n_rg, n_a, n_b, n_s, n_st, n_bad;

    // Device under test and sensor stand-in
    htg_timing_gen htg_timing_gen_i (.clock(clock), .sys_rst(sys_rst), .line_sync(ls),
        .frame_sync(fs), .rg_cfg(rg), .phase_a_cfg(pa), .phase_b_cfg(pb),
        .phase_a_inv_drive(3'h3), .phase_b_inv_drive(3'h1), .reference_sample_place(6'h00),
        .data_sample_place(6'h20), .output_data_launch_edge(6'h05), .black_clamp_cfg(bc),
        .dummy_clamp_cfg(dc), .preblank_cfg(pk), .blank_cfg(hk), .adc_data(ad),
        .reset_gate_clock(rgc), .hclk_phase_a(ha), .hclk_phase_a_inv(hai), .hclk_phase_b(hb),
        .hclk_phase_b_inv(hbi), .reference_sample_clock(rs), .data_sample_clock(ds),
        .pad_ctrl(pad), .data_out(dout), .data_launch_strobe(stb), .black_clamp_pulse(bcp),
        .dummy_clamp_pulse(dcp), .preblank_pulse(pbp), .horizontal_blank_pulse(hbp),
        .pixel_count(pix), .line_count(lin));
    htg_ccd_model htg_ccd_model_i (.hclk_phase_a(ha), .hclk_phase_a_inv(hai), .shift_count(sh));

    // Clock generation
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Helper tasks
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_pix(input logic [11:0] p);
        for (int i = 0; i < 4000 && pix !== p; i++) tk(1);
        chk(pix, p);
    endtask
    task automatic measure();
        {n_rg, n_a, n_b, n_s, n_st, n_bad} = '0;
        repeat (48) begin
            tk(1);
            n_rg += rgc;
            n_a += ha;
            n_b += hb;
            n_s += rs + ds;
            n_st += stb;
            n_bad += (hai !== ~ha) + (hbi !== ~hb);
        end
    endtask
    task automatic sync_pulse(input logic frame);
        if (frame) fs = 1'b0;
        else ls = 1'b0;
        tk(10);
        {ls, fs} = 2'b11;
        tk(5);
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Line 1: clamp windows and masked blanking, then edge placement
    task automatic t_line1();
        sync_pulse(1'b1);
        sync_pulse(1'b0);
        wait_pix(12'h000);
        wait_pix(12'h00f);
        tk(24);
        chk({bcp, dcp, pbp, hbp}, 4'h1);
        measure();
        chk({n_a, n_b}, 64'h0);
        wait_pix(12'h023);
        chk({bcp, hbp}, 2'b10);
        sh0 = sh;
        measure();
        chk(n_rg, 32'd12);
        chk({n_a, n_b}, {32'd12, 32'd31});
        chk({n_s, n_st, n_bad}, {32'd48, 32'd1, 32'd0});
        chk({dout, sh - sh0}, {12'h5a3, 16'h0001});
        chk(pad, {9'h123, 9'h146, 9'h169, 9'h000, 9'h1f5});
    endtask

    // Line 2: second region swaps the sequence of one signal only
    task automatic t_line2();
        ad = 12'h3c6;
        sync_pulse(1'b0);
        wait_pix(12'h000);
        wait_pix(12'h019);
        tk(24);
        chk({lin, bcp, dcp}, {12'h002, 2'b01});
        chk(dout, 12'h3c6);
        sync_pulse(1'b1);
        chk(lin, 12'h000);
    endtask

    // Stimulus, reset and scenarios
    initial begin
        {sys_rst, ls, fs} = 3'b111;
        ad = 12'h5a3;
        rg = {1'b0, 6'h10, 6'h20, 3'h7};
        pa = {1'b1, 6'h00, 6'h30, 3'h0};
        pb = {1'b0, 6'h04, 6'h2b, 3'h2};
        bc = '0;
        bc.seq[0] = {1'b1, 12'h00a, 12'h014};
        bc.seq[1] = {1'b0, 12'h800, 12'h900};
        bc.region_start_line = {12'hfff, 12'hfff, 12'h002};
        bc.region_sequence_select = {2'h0, 2'h0, 2'h1, 2'h0};
        dc = bc;
        dc.region_start_line = {3{12'hfff}};
        pk = dc;
        hk = dc;
        hk.seq[0] = {1'b1, 12'h005, 12'h01e};
        tk(8);
        chk({bcp, hbp, rgc, pad[0], pix}, {3'b100, 9'h000, 12'h000});
        sys_rst = 1'b0;
        tk(960);
        t_line1();
        t_line2();
        final_report();
    end

    // Watchdog against a hang
    initial begin
        #600000;
        error_cnt++;
        final_report();
    end
endmodule // test_ccd_horizontal_timing_gen
